// *** ethrb_builder.sv ***
// Notes on behaviour
// - Flag word sits in record bytes 20..23, bit 0 least significant.
// - Flag bit 31 set for frames that came from a transmission.
// - Direct monitor: host-submitted transmit frames are echoed with transmit flag.
// - Tap monitor: frames the tap partner received and sent here are transmit.
// - Flag bit 30 set for frames that came from reception.
// - Direct monitor: frames arriving on this port carry the receive flag.
// - Tap monitor: frames this port received, forwarded to partner, are receive.
// - Endpoint path: every record carries the receive flag.
// - Network-synced status sampled at timestamp capture goes to flag bit 23.
// - Flag bit 16 marks a frame with an error, clear for good frames.
// - Undefined flag bits are zero; host-supplied flag words are ignored.
// - Frame bytes fill record byte 24 up to length minus 5.
// - Received FCS fills the last four record bytes; host FCS ignored.
// - Tap mode timestamps refer to midpoint between both reference planes.
// - Destination MAC at bytes 24..29, source MAC at 30..35.
// - Untagged: EtherType at 36..37, payload from 38 onward.
// - Payload at least 46 bytes and at most the Ethernet MTU.
// - Untagged frames report priority 0, drop-eligible false, VLAN id 1.
// - Bytes 0..1 hold total record length; frame bytes equal length minus 28.
// - Bytes 2..3 hold record type, 0 for an ordinary frame.
// - Local time bytes 4..11, network time 12..19, ns counts at first symbol.
// - Direct mode timestamps refer to the connector/PHY reference plane.
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module ethrb_builder
	import ethrb_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire ethrb_wire_s wire_in,
	input wire logic frame_from_link,
	input wire logic [63:0] local_time,
	input wire logic [63:0] network_time,
	input wire logic network_synced,
	input wire logic [7:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic bus_write,
	input wire logic bus_read,
	output logic [31:0] bus_rdata,
	output logic record_ready
);

	// Flag word for a new record
	function automatic logic [31:0] make_flags(input logic endpoint, input logic from_link,
			input logic synced, input logic err);
		logic [31:0] f;
		f = '0;
		f[ETHRB_FLAG_TX] = !endpoint && !from_link;
		f[ETHRB_FLAG_RX] = endpoint || from_link;
		f[ETHRB_FLAG_SYNC] = synced;
		f[ETHRB_FLAG_ERR] = err;
		return f;
	endfunction : make_flags

	// Header byte at index 0..23, multi-byte fields little endian
	function automatic logic [7:0] hdr_byte(input ethrb_meta_s m, input logic [4:0] idx);
		logic [191:0] hdr;
		hdr = {m.flags, m.ntime, m.ltime, ETHRB_REC_TYPE_FRAME, m.len};
		return hdr[{idx, 3'b000} +: 8];
	endfunction : hdr_byte

	// Frame store, both banks in one array, bank is the top address bit
	logic [7:0] frame_mem [0:(2*ETHRB_BUF_DEPTH)-1];

	logic [1:0] ctrl;
	logic [1:0] next_ctrl;
	logic [15:0] tap_ofs;
	logic [15:0] next_tap_ofs;
	logic overrun;
	logic next_overrun;

	logic cap_active;
	logic next_cap_active;
	logic cap_bank;
	logic next_cap_bank;
	logic [15:0] cap_cnt;
	logic [15:0] next_cap_cnt;
	logic [15:0] cap_etype;
	logic [15:0] next_cap_etype;
	logic [15:0] cap_tci;
	logic [15:0] next_cap_tci;
	ethrb_meta_s cap_meta;
	ethrb_meta_s next_cap_meta;
	logic wr_bank;
	logic next_wr_bank;

	logic [1:0] bank_full;
	logic [1:0] next_bank_full;
	ethrb_meta_s bank_meta [0:1];
	ethrb_meta_s next_bank_meta [0:1];
	logic rd_bank;
	logic next_rd_bank;
	logic [15:0] rd_idx;
	logic [15:0] next_rd_idx;
	logic [31:0] next_rdata;
	logic next_record_ready;

	logic cap_start;
	logic cap_fin;
	logic overrun_set;
	logic mem_we;
	logic [ETHRB_BUF_AW:0] mem_wa;
	logic [15:0] fin_cnt;
	logic fin_err;
	logic pop;
	logic last_pop;
	logic [7:0] rec_byte;
	logic [15:0] data_idx;
	ethrb_meta_s cur;

	logic is_tap;
	logic is_endpoint;
	assign is_tap = ctrl[ETHRB_CTRL_TAP];
	assign is_endpoint = ctrl[ETHRB_CTRL_ENDPOINT];

	// Capture side: stamps, flags and bytes of the frame on the wire
	always_comb begin
		next_cap_active = cap_active;
		next_cap_bank = cap_bank;
		next_cap_cnt = cap_cnt;
		next_cap_etype = cap_etype;
		next_cap_tci = cap_tci;
		next_cap_meta = cap_meta;
		next_wr_bank = wr_bank;
		cap_start = 1'b0;
		cap_fin = 1'b0;
		overrun_set = 1'b0;
		mem_we = 1'b0;
		mem_wa = {wr_bank, {ETHRB_BUF_AW{1'b0}}};
		fin_cnt = cap_cnt;
		fin_err = 1'b0;
		if (wire_in.valid && wire_in.first) begin
			if (bank_full[wr_bank]) begin
				// No free bank; the frame cannot be held, so it is dropped and the overrun flag is set
				overrun_set = 1'b1;
				next_cap_active = 1'b0;
			end else begin
				cap_start = 1'b1;
				next_cap_active = 1'b1;
				next_cap_bank = wr_bank;
				next_cap_cnt = 16'h0001;
				mem_we = 1'b1;
				next_cap_meta.ltime = local_time;
				next_cap_meta.ntime = network_time;
				if (is_tap) begin
					next_cap_meta.ltime = local_time + {48'h0000_0000_0000, tap_ofs};
					next_cap_meta.ntime = network_time + {48'h0000_0000_0000, tap_ofs};
				end
				next_cap_meta.flags = make_flags(is_endpoint, frame_from_link,
					network_synced, wire_in.err);
				next_cap_meta.tci = {ETHRB_DEF_PCP, ETHRB_DEF_DEI, ETHRB_DEF_VID};
				next_cap_etype = 16'h0000;
				next_cap_tci = 16'h0000;
				cap_fin = wire_in.last;
			end
		end else if (cap_active && wire_in.valid) begin
			mem_wa = {cap_bank, cap_cnt[ETHRB_BUF_AW-1:0]};
			if (cap_cnt < ETHRB_BUF_DEPTH) begin
				mem_we = 1'b1;
				next_cap_cnt = cap_cnt + 16'h0001;
			end else begin
				next_cap_meta.flags[ETHRB_FLAG_ERR] = 1'b1;
			end
			if (wire_in.err) begin
				next_cap_meta.flags[ETHRB_FLAG_ERR] = 1'b1;
			end
			if (cap_cnt[ETHRB_BUF_AW-1:0] == ETHRB_IDX_ETYPE_HI ||
					cap_cnt[ETHRB_BUF_AW-1:0] == ETHRB_IDX_ETYPE_LO) begin
				next_cap_etype = {cap_etype[7:0], wire_in.data};
			end
			if (cap_cnt[ETHRB_BUF_AW-1:0] == ETHRB_IDX_TCI_HI ||
					cap_cnt[ETHRB_BUF_AW-1:0] == ETHRB_IDX_TCI_LO) begin
				next_cap_tci = {cap_tci[7:0], wire_in.data};
			end
			cap_fin = wire_in.last;
		end
		if (cap_fin) begin
			fin_cnt = next_cap_cnt;
			// size check feeds the error flag
			fin_err = fin_cnt < ETHRB_MIN_FRAME || fin_cnt > ETHRB_LONG_FRAME;
			if (fin_err) begin
				next_cap_meta.flags[ETHRB_FLAG_ERR] = 1'b1;
			end
			// length covers header, frame bytes and FCS
			next_cap_meta.len = fin_cnt + ETHRB_HDR_BYTES;
			// defaults stay unless a customer tag is present
			if (next_cap_etype == ETHRB_TPID_CTAG) begin
				next_cap_meta.tci = next_cap_tci;
			end
			next_cap_active = 1'b0;
			next_wr_bank = !wr_bank;
		end
	end

	// Memory write port; contents need no reset
	always_ff @(posedge clk) begin
		if (mem_we) begin
			frame_mem[mem_wa] <= wire_in.data;
		end
	end

	// Register side: record readout, control and status
	always_comb begin
		cur = bank_meta[rd_bank];
		next_ctrl = ctrl;
		next_tap_ofs = tap_ofs;
		next_rd_bank = rd_bank;
		next_rd_idx = rd_idx;
		next_bank_full = bank_full;
		next_bank_meta = bank_meta;
		next_rdata = 32'h0000_0000;
		data_idx = rd_idx - ETHRB_HDR_BYTES;
		pop = bus_read && bus_addr == ETHRB_ADDR_DATA && bank_full[rd_bank];
		last_pop = pop && rd_idx == cur.len - 16'h0001;
		// header bytes, then frame bytes from the store
		if (rd_idx < ETHRB_HDR_BYTES) begin
			rec_byte = hdr_byte(cur, rd_idx[4:0]);
		end else begin
			// FCS is simply the tail of the stored wire bytes
			rec_byte = frame_mem[{rd_bank, data_idx[ETHRB_BUF_AW-1:0]}];
		end
		if (bus_read) begin
			unique case (bus_addr)
				ETHRB_ADDR_CTRL: next_rdata = {30'h0000_0000, ctrl};
				ETHRB_ADDR_STATUS: next_rdata = {bank_full[rd_bank] ? cur.len : 16'h0000,
					14'h0000, overrun, bank_full[rd_bank]};
				ETHRB_ADDR_DATA: next_rdata = pop ? {24'h00_0000, rec_byte} : 32'h0000_0000;
				ETHRB_ADDR_TAP_OFS: next_rdata = {16'h0000, tap_ofs};
				ETHRB_ADDR_VLAN: next_rdata = {16'h0000, bank_full[rd_bank] ? cur.tci : 16'h0000};
				default: next_rdata = 32'h0000_0000;
			endcase
		end
		if (bus_write && bus_addr == ETHRB_ADDR_CTRL) begin
			next_ctrl = bus_wdata[1:0];
		end
		if (bus_write && bus_addr == ETHRB_ADDR_TAP_OFS) begin
			next_tap_ofs = bus_wdata[15:0];
		end
		// Overrun: write one to clear, a new loss in the same cycle wins
		next_overrun = overrun;
		if (bus_write && bus_addr == ETHRB_ADDR_STATUS && bus_wdata[ETHRB_STAT_OVERRUN]) begin
			next_overrun = 1'b0;
		end
		if (overrun_set) begin
			next_overrun = 1'b1;
		end
		// banks drain strictly in fill order
		if (pop) begin
			next_rd_idx = rd_idx + 16'h0001;
		end
		if (last_pop) begin
			next_rd_idx = 16'h0000;
			next_rd_bank = !rd_bank;
			next_bank_full[rd_bank] = 1'b0;
		end
		// errored frames are stored like good ones
		if (cap_fin) begin
			next_bank_full[cap_start ? wr_bank : cap_bank] = 1'b1;
			next_bank_meta[cap_start ? wr_bank : cap_bank] = next_cap_meta;
		end
		next_record_ready = next_bank_full[next_rd_bank];
	end

	// Register all state
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl <= ETHRB_CTRL_RESET;
			tap_ofs <= ETHRB_TAP_OFS_RESET;
			overrun <= 1'b0;
			cap_active <= 1'b0;
			cap_bank <= 1'b0;
			cap_cnt <= 16'h0000;
			cap_etype <= 16'h0000;
			cap_tci <= 16'h0000;
			cap_meta <= '0;
			wr_bank <= 1'b0;
			bank_full <= 2'b00;
			bank_meta[0] <= '0;
			bank_meta[1] <= '0;
			rd_bank <= 1'b0;
			rd_idx <= 16'h0000;
			bus_rdata <= 32'h0000_0000;
			record_ready <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			tap_ofs <= next_tap_ofs;
			overrun <= next_overrun;
			cap_active <= next_cap_active;
			cap_bank <= next_cap_bank;
			cap_cnt <= next_cap_cnt;
			cap_etype <= next_cap_etype;
			cap_tci <= next_cap_tci;
			cap_meta <= next_cap_meta;
			wr_bank <= next_wr_bank;
			bank_full <= next_bank_full;
			bank_meta[0] <= next_bank_meta[0];
			bank_meta[1] <= next_bank_meta[1];
			rd_bank <= next_rd_bank;
			rd_idx <= next_rd_idx;
			bus_rdata <= next_rdata;
			record_ready <= next_record_ready;
		end
	end

	// Checks of the observable record contents
	logic fin_q;
	logic fin_bank_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fin_q <= 1'b0;
			fin_bank_q <= 1'b0;
		end else begin
			fin_q <= cap_fin;
			fin_bank_q <= cap_start ? wr_bank : cap_bank;
		end
	end

	sequence s_finish;
		fin_q;
	endsequence

	sequence s_pop_at(int idx);
		pop && rd_idx == idx;
	endsequence

	property p_flag_reserved;
		@(posedge clk) disable iff (!reset_n)
		s_finish |-> (bank_meta[fin_bank_q].flags & ~ETHRB_FLAG_MASK) == 32'h0000_0000;
	endproperty
	a_flag_reserved: assert property (p_flag_reserved) else $error("reserved flag bit set");

	property p_endpoint_rx;
		@(posedge clk) disable iff (!reset_n)
		cap_start && is_endpoint |=> cap_meta.flags[ETHRB_FLAG_RX] && !cap_meta.flags[ETHRB_FLAG_TX];
	endproperty
	a_endpoint_rx: assert property (p_endpoint_rx) else $error("endpoint record not rx");

	property p_monitor_dir;
		@(posedge clk) disable iff (!reset_n)
		cap_start && !is_endpoint |=> cap_meta.flags[ETHRB_FLAG_TX] == !$past(frame_from_link)
			&& cap_meta.flags[ETHRB_FLAG_RX] == $past(frame_from_link);
	endproperty
	a_monitor_dir: assert property (p_monitor_dir) else $error("monitor direction flag wrong");

	property p_sync;
		@(posedge clk) disable iff (!reset_n)
		cap_start |=> cap_meta.flags[ETHRB_FLAG_SYNC] == $past(network_synced);
	endproperty
	a_sync: assert property (p_sync) else $error("synced flag not sampled at stamp");

	property p_stamp;
		@(posedge clk) disable iff (!reset_n)
		cap_start |=> cap_meta.ltime == $past(local_time) + (is_tap ? {48'h0000_0000_0000, tap_ofs} : 64'h0)
			&& cap_meta.ntime - cap_meta.ltime == $past(network_time) - $past(local_time);
	endproperty
	a_stamp: assert property (p_stamp) else $error("timestamp capture wrong");

	property p_len;
		@(posedge clk) disable iff (!reset_n)
		cap_fin ##1 s_finish |-> bank_full[fin_bank_q]
			&& bank_meta[fin_bank_q].len == $past(fin_cnt) + ETHRB_HDR_BYTES;
	endproperty
	a_len: assert property (p_len) else $error("record length wrong");

	property p_short_err;
		@(posedge clk) disable iff (!reset_n)
		s_finish ##0 (bank_meta[fin_bank_q].len < ETHRB_MIN_FRAME + ETHRB_HDR_BYTES)
			|-> bank_meta[fin_bank_q].flags[ETHRB_FLAG_ERR];
	endproperty
	a_short_err: assert property (p_short_err) else $error("runt frame not flagged");

	property p_type;
		@(posedge clk) disable iff (!reset_n)
		(s_pop_at(2) or s_pop_at(3)) |=> bus_rdata == 32'h0000_0000;
	endproperty
	a_type: assert property (p_type) else $error("record type not zero");

	property p_len_byte;
		@(posedge clk) disable iff (!reset_n)
		s_pop_at(0) |=> bus_rdata == {24'h00_0000, $past(cur.len[7:0])};
	endproperty
	a_len_byte: assert property (p_len_byte) else $error("length byte wrong");

	property p_order;
		@(posedge clk) disable iff (!reset_n)
		last_pop |=> rd_bank != $past(rd_bank) && rd_idx == 16'h0000 && !bank_full[$past(rd_bank)];
	endproperty
	a_order: assert property (p_order) else $error("bank not released in order");

endmodule : ethrb_builder

`default_nettype wire

// *** ethrb_pkg.sv ***
`default_nettype none

package ethrb_pkg;

	// Frame store: one bank per record, two banks for ping-pong
	localparam int ETHRB_BUF_AW = 11;
	localparam logic [15:0] ETHRB_BUF_DEPTH = 16'h0800;

	// Record layout
	localparam logic [15:0] ETHRB_HDR_BYTES = 16'h0018;
	localparam logic [15:0] ETHRB_REC_TYPE_FRAME = 16'h0000;
	localparam int ETHRB_FLAG_TX = 31;
	localparam int ETHRB_FLAG_RX = 30;
	localparam int ETHRB_FLAG_SYNC = 23;
	localparam int ETHRB_FLAG_ERR = 16;
	localparam logic [31:0] ETHRB_FLAG_MASK = 32'hc081_0000;

	// Wire frame limits, FCS included: 60 + 4 up to tagged 1518 + 4
	localparam logic [15:0] ETHRB_MIN_FRAME = 16'h0040;
	localparam logic [15:0] ETHRB_LONG_FRAME = 16'h05f2;

	// Tag detection and untagged defaults
	localparam logic [ETHRB_BUF_AW-1:0] ETHRB_IDX_ETYPE_HI = 11'h00c;
	localparam logic [ETHRB_BUF_AW-1:0] ETHRB_IDX_ETYPE_LO = 11'h00d;
	localparam logic [ETHRB_BUF_AW-1:0] ETHRB_IDX_TCI_HI = 11'h00e;
	localparam logic [ETHRB_BUF_AW-1:0] ETHRB_IDX_TCI_LO = 11'h00f;
	localparam logic [15:0] ETHRB_TPID_CTAG = 16'h8100;
	localparam logic [2:0] ETHRB_DEF_PCP = 3'h0;
	localparam logic ETHRB_DEF_DEI = 1'b0;
	localparam logic [11:0] ETHRB_DEF_VID = 12'h001;

	// Register map
	localparam logic [7:0] ETHRB_ADDR_CTRL = 8'h00;
	localparam logic [7:0] ETHRB_ADDR_STATUS = 8'h04;
	localparam logic [7:0] ETHRB_ADDR_DATA = 8'h08;
	localparam logic [7:0] ETHRB_ADDR_TAP_OFS = 8'h0c;
	localparam logic [7:0] ETHRB_ADDR_VLAN = 8'h10;
	localparam int ETHRB_CTRL_TAP = 0;
	localparam int ETHRB_CTRL_ENDPOINT = 1;
	localparam int ETHRB_STAT_READY = 0;
	localparam int ETHRB_STAT_OVERRUN = 1;
	localparam logic [1:0] ETHRB_CTRL_RESET = 2'h0;
	localparam logic [15:0] ETHRB_TAP_OFS_RESET = 16'h0000;

	// Byte stream from the PHY side, one byte per valid cycle
	typedef struct packed {
		logic valid;
		logic first;
		logic last;
		logic err;
		logic [7:0] data;
	} ethrb_wire_s;

	// Everything a record holds besides the frame bytes
	typedef struct packed {
		logic [15:0] len;
		logic [31:0] flags;
		logic [63:0] ltime;
		logic [63:0] ntime;
		logic [15:0] tci;
	} ethrb_meta_s;

endpackage : ethrb_pkg

`default_nettype wire

// *** ethrb_link_partner.sv ***
`timescale 1ns/1ps
`default_nettype none

// Link side: one frame at a time, one byte per cycle, no gaps inside a frame
module ethrb_link_partner
	import ethrb_pkg::*;
(
	input wire logic clk,
	output var ethrb_wire_s wire_out,
	output logic frame_from_link
);
	logic [7:0] q[$];

	// Idle line at time zero
	initial begin
		wire_out = '0;
		frame_from_link = 1'b0;
	end

	// legal sizes are chosen by whoever fills the queue
	// Source flag flips after the first byte, since only that byte counts
	task automatic send(input int err_at, input logic link);
		int n;
		n = q.size();
		for (int i = 0; i < n; i++) begin
			wire_out <= '{1'b1, i == 0, i == n - 1, i == err_at, q[i]};
			frame_from_link <= (i == 0) ? link : ~link;
			@(posedge clk);
		end
		q.delete();
	endtask : send

	// Released line shows the inverse byte so stale data cannot pass
	task automatic quiet();
		wire_out <= '{1'b0, 1'b0, 1'b0, 1'b0, ~wire_out.data};
		@(posedge clk);
	endtask : quiet

endmodule : ethrb_link_partner

`default_nettype wire

// *** ethrb_builder_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, s) begin total_checks++; if ((s) !== (e)) begin err_total++; \
	$display("ERROR %s expected %h seen %h", nm, e, s); end end

module ethrb_builder_tb;
	import ethrb_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	ethrb_wire_s wire_in;
	logic ffl;
	logic [63:0] ltime = '0;
	logic [63:0] ntime = '0;
	logic sync = 1'b0;
	logic [7:0] addr = '0;
	logic [31:0] wdata = '0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic rdy;
	logic [31:0] seed = 32'h0000_002a;
	logic [31:0] d;
	logic [31:0] r;
	logic [1:0] ctrl = 2'h0;
	logic [15:0] ofs = 16'h0000;
	int err_total = 0;
	int total_checks = 0;
	logic [7:0] exp_b[$];
	int exp_len[$];
	logic [15:0] exp_tci[$];

	// Free clock, 25 ns period
	always #12.5 clk = ~clk;

	ethrb_builder ethrb_builder_i (
		.clk(clk), .reset_n(reset_n), .wire_in(wire_in), .frame_from_link(ffl),
		.local_time(ltime), .network_time(ntime), .network_synced(sync),
		.bus_addr(addr), .bus_wdata(wdata), .bus_write(wr), .bus_read(rd),
		.bus_rdata(rdata), .record_ready(rdy)
	);

	ethrb_link_partner ethrb_link_partner_i (
		.clk(clk), .wire_out(wire_in), .frame_from_link(ffl)
	);

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	task automatic results();
		$display("Checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : results

	task automatic bw(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : bw

	// Read data stands only in the cycle after the strobe
	task automatic br(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask : br

	// Builds one frame, predicts its record, sends it without a trailing gap
	task automatic frame(input int n, input logic link, input int err_at, input logic tag,
		input logic keep);
		logic [7:0] b;
		logic [15:0] tci;
		logic [31:0] fl;
		logic [63:0] lt;
		logic [63:0] nt;
		logic [191:0] hdr;
		logic sy;
		lt = {rnd(), rnd()};
		nt = {rnd(), rnd()};
		r = rnd();
		sy = r[0];
		tci = tag ? r[31:16] : ETHRB_DEF_VID;
		ltime <= lt;
		ntime <= nt;
		sync <= sy;
		if (ctrl[0]) begin
			lt = lt + ofs;
			nt = nt + ofs;
		end
		fl = 32'h0000_0000;
		fl[ETHRB_FLAG_RX] = ctrl[1] | link;
		fl[ETHRB_FLAG_TX] = ~ctrl[1] & ~link;
		fl[ETHRB_FLAG_SYNC] = sy;
		fl[ETHRB_FLAG_ERR] = err_at >= 0 || n < ETHRB_MIN_FRAME || n > ETHRB_LONG_FRAME;
		hdr = {fl, nt, lt, ETHRB_REC_TYPE_FRAME, 16'(n + 24)};
		if (keep) begin
			exp_len.push_back(n + 24);
			exp_tci.push_back(tci);
			for (int i = 0; i < 24; i++) begin
				exp_b.push_back(hdr[8*i +: 8]);
			end
		end
		for (int i = 0; i < n; i++) begin
			r = rnd();
			b = r[7:0];
			if (i == 12) b = tag ? 8'h81 : 8'h08;
			if (i == 13 && tag) b = 8'h00;
			if (i == 14 && tag) b = tci[15:8];
			if (i == 15 && tag) b = tci[7:0];
			ethrb_link_partner_i.q.push_back(b);
			if (keep) exp_b.push_back(b);
		end
		ethrb_link_partner_i.send(err_at, link);
	endtask : frame

	// Pops one whole record and compares every byte
	task automatic drain();
		int len;
		logic [7:0] eb;
		logic [15:0] et;
		len = exp_len.pop_front();
		et = exp_tci.pop_front();
		for (int i = 0; i < 200 && rdy !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		`CHK("ready", 1'b1, rdy)
		if (rdy !== 1'b1) results();
		br(ETHRB_ADDR_STATUS);
		`CHK("status_len", len[15:0], d[31:16])
		br(ETHRB_ADDR_VLAN);
		`CHK("tci", et, d[15:0])
		for (int i = 0; i < len; i++) begin
			eb = exp_b.pop_front();
			br(ETHRB_ADDR_DATA);
			`CHK("rec_byte", {24'h00_0000, eb}, d)
		end
		@(posedge clk);
		#1;
		`CHK("ready_after", exp_len.size() > 0, rdy)
	endtask : drain

	initial begin
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		// Reset values and refused accesses
		br(ETHRB_ADDR_CTRL);
		`CHK("ctrl_reset", 32'h0000_0000, d)
		br(ETHRB_ADDR_DATA);
		`CHK("data_empty", 32'h0000_0000, d)
		bw(8'h44, 32'hffff_ffff);
		br(8'h44);
		`CHK("unmapped", 32'h0000_0000, d)
		$display("test reset done");
		// Every attachment, both sources, boundary sizes
		for (int m = 0; m < 4; m++) begin
			for (int l = 0; l < 2; l++) begin
				ctrl = m[1:0];
				r = rnd();
				ofs = r[15:0];
				bw(ETHRB_ADDR_CTRL, {30'h0, ctrl});
				bw(ETHRB_ADDR_TAP_OFS, {16'h0000, ofs});
				br(ETHRB_ADDR_TAP_OFS);
				`CHK("tap_ofs", ofs, d[15:0])
				@(posedge clk);
				frame(l ? 64 : (m == 1 ? 1522 : 1518), l[0], -1, m == 1, 1'b1);
				ethrb_link_partner_i.quiet();
				drain();
			end
		end
		$display("test modes done");
		// Errored and short frames back to back are still delivered
		ctrl = 2'h0;
		bw(ETHRB_ADDR_CTRL, 32'h0000_0000);
		@(posedge clk);
		frame(80, 1'b1, 40, 1'b0, 1'b1);
		frame(60, 1'b0, -1, 1'b0, 1'b1);
		ethrb_link_partner_i.quiet();
		drain();
		drain();
		$display("test errors done");
		// Third frame with both banks full is lost, order kept
		@(posedge clk);
		for (int k = 0; k < 3; k++) begin
			r = rnd();
			frame(64 + r[6:0], r[8], -1, 1'b0, k < 2);
		end
		ethrb_link_partner_i.quiet();
		br(ETHRB_ADDR_STATUS);
		`CHK("overrun", 1'b1, d[ETHRB_STAT_OVERRUN])
		`CHK("status_ready", 1'b1, d[ETHRB_STAT_READY])
		bw(ETHRB_ADDR_STATUS, 32'h0000_0002);
		br(ETHRB_ADDR_STATUS);
		`CHK("overrun_clr", 1'b0, d[ETHRB_STAT_OVERRUN])
		drain();
		drain();
		$display("test overrun done");
		results();
	end

endmodule : ethrb_builder_tb

`default_nettype wire
